// ===== design/pmc_top.sv
// pwm master control: axi4-lite registers, double buffering, output gating
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"

module pmc_top
    import pmc_pkg::*;
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire pmc_axi_req_s axi_req,
    output var  pmc_axi_rsp_s axi_rsp,
    output var  logic [5:0]   pwm_out,
    output var  logic         adc_trigger
);

    typedef struct packed {
        logic                  awready;
        logic                  wready;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  arready;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
        logic                  aw_held;
        logic                  w_held;
        logic [23:0]           waddr;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic [7:0]            ctl;
        logic [5:0]            ovr;
        logic [7:0]            cfg;
        pmc_cnt_t              period_h;
        logic [2:0][13:0]      duty_h;
        logic [1:0]            pres_w;
        pmc_cnt_t              period_w;
        logic [2:0][13:0]      duty_w;
        logic                  mod_ctl;
        logic [5:0]            pwm;
        logic                  adc;
    } pmc_top_st_s;

    pmc_top_st_s q;
    pmc_top_st_s d;
    pmc_tb_evt_s evt;
    pmc_tb_cfg_s tb_cfg;
    logic [2:0]  mod_on;

    assign tb_cfg = '{align:    pmc_align_e'(q.ctl[`PMC_CTL_ALIGN]),
                      period:   q.period_w,
                      prescale: q.pres_w,
                      reload_frequency_sel: q.cfg[`PMC_CFG_RLF_LSB +: 2]};

    pmc_timebase u_timebase (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (q.ctl[`PMC_CTL_ENABLE]),
        .cfg     (tb_cfg),
        .evt     (evt)
    );

    // negative duty forces off, duty above the period forces on
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_cmp
            always_comb
            begin
                if (q.duty_w[gi][`PMC_DUTY_SIGN])
                    mod_on[gi] = 1'b0;
                else if (q.duty_w[gi] > {2'h0, q.period_w})
                    mod_on[gi] = 1'b1;
                else
                    mod_on[gi] = {2'h0, evt.count} < q.duty_w[gi];
            end
        end
    endgenerate

    function automatic logic [31:0] rd_mux(input pmc_top_st_s s,
                                           input pmc_tb_evt_s e,
                                           input logic [23:0] a);
        rd_mux = '0;
        unique case (a)
            `PMC_OFS_CTL:    rd_mux[7:0]  = s.ctl;
            `PMC_OFS_OVR:    rd_mux[5:0]  = s.ovr;
            `PMC_OFS_CFG:    rd_mux[7:0]  = s.cfg;
            `PMC_OFS_PERIOD: rd_mux[11:0] = s.period_h;
            `PMC_OFS_DUTY0:  rd_mux[13:0] = s.duty_h[0];
            `PMC_OFS_DUTY1:  rd_mux[13:0] = s.duty_h[1];
            `PMC_OFS_DUTY2:  rd_mux[13:0] = s.duty_h[2];
            `PMC_OFS_STATUS:
            begin
                rd_mux[11:0]              = e.count;
                rd_mux[`PMC_STAT_MOD_LSB] = s.mod_ctl;
                rd_mux[`PMC_STAT_RUN_LSB] = s.ctl[`PMC_CTL_ENABLE];
            end
            default:         rd_mux       = '0;
        endcase
    endfunction

    function automatic logic mapped(input logic [23:0] a);
        mapped = (a >= `PMC_OFS_CTL) && (a <= `PMC_OFS_STATUS);
    endfunction

    always_comb
    begin
        logic [23:0] ra;
        logic [31:0] m;
        logic [5:0]  pins;
        ra   = '0;
        m    = '0;
        pins = '0;
        d    = q;

        // write channels are taken independently, in either order
        if (axi_req.awvalid && q.awready)
        begin
            d.aw_held = 1'b1;
            d.waddr   = {axi_req.awaddr[23:2], 2'h0};
        end
        if (axi_req.wvalid && q.wready)
        begin
            d.w_held = 1'b1;
            d.wdata  = axi_req.wdata;
            d.wstrb  = axi_req.wstrb;
        end
        if (q.bvalid && axi_req.bready)
            d.bvalid = 1'b0;

        // reload transfer: ready consumed, a same-cycle write re-arms it
        if (evt.reload && q.ctl[`PMC_CTL_READY])
        begin
            d.pres_w   = q.cfg[`PMC_CFG_PRES_LSB +: 2];
            d.period_w = q.period_h;
            d.duty_w   = q.duty_h;
            d.ctl[`PMC_CTL_READY] = 1'b0;
        end

        if (q.aw_held && q.w_held && !q.bvalid)
        begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = mapped(q.waddr) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
            m = pmc_merge(rd_mux(q, evt, q.waddr), q.wdata, q.wstrb);
            unique case (q.waddr)
                `PMC_OFS_CTL:    d.ctl       = m[7:0];
                `PMC_OFS_OVR:    d.ovr       = m[5:0];
                `PMC_OFS_CFG:    d.cfg       = m[7:0];
                `PMC_OFS_PERIOD: d.period_h  = m[11:0];
                `PMC_OFS_DUTY0:  d.duty_h[0] = m[13:0];
                `PMC_OFS_DUTY1:  d.duty_h[1] = m[13:0];
                `PMC_OFS_DUTY2:  d.duty_h[2] = m[13:0];
                default:         d.ctl       = d.ctl;
            endcase
        end
        d.awready = !d.aw_held && !d.bvalid;
        d.wready  = !d.w_held && !d.bvalid;

        if (q.rvalid && axi_req.rready)
            d.rvalid = 1'b0;
        if (axi_req.arvalid && q.arready)
        begin
            ra       = {axi_req.araddr[23:2], 2'h0};
            d.rvalid = 1'b1;
            d.rdata  = rd_mux(q, evt, ra);
            d.rresp  = mapped(ra) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
        end
        d.arready = !d.rvalid;

        // shutdown is immediate, hand-back waits for the reload event
        if (!d.ctl[`PMC_CTL_SHUTDOWN])
            d.mod_ctl = 1'b0;
        else if (evt.reload && q.ctl[`PMC_CTL_SHUTDOWN])
            d.mod_ctl = 1'b1;

        // even pins are high sides, odd pins their complements;
        // no deadband here, the deadband stage sits downstream
        for (int i = 0; i < 3; i++)
        begin
            pins[2*i]   = mod_on[i];
            pins[2*i+1] = !mod_on[i];
        end
        if (d.ctl[`PMC_CTL_OVR_SEL])
            pins = (pins & ~d.ovr) | (`PMC_OFF_LEVEL & d.ovr);
        if (!d.ctl[`PMC_CTL_ENABLE] || !d.mod_ctl)
            pins = `PMC_OFF_LEVEL;
        d.pwm = pins;

        d.adc = evt.period_end && d.ctl[`PMC_CTL_ADC_EN]
                && d.ctl[`PMC_CTL_ENABLE];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q          <= '0;
            q.ctl      <= `PMC_CTL_RESET;
            q.cfg      <= `PMC_CFG_RESET;
            q.ovr      <= `PMC_OVR_RESET;
            q.period_h <= `PMC_PERIOD_RESET;
            q.period_w <= `PMC_PERIOD_RESET;
            q.pwm      <= `PMC_OFF_LEVEL;
        end
        else
            q <= d;
    end

    assign axi_rsp = '{awready: q.awready, wready: q.wready,
                       bresp: q.bresp, bvalid: q.bvalid,
                       arready: q.arready, rdata: q.rdata,
                       rresp: q.rresp, rvalid: q.rvalid};
    assign pwm_out     = q.pwm;
    assign adc_trigger = q.adc;

endmodule
`default_nettype wire

// ===== design/pmc_map.svh
// register map, field positions and reset values of the pwm master control
// Behaviour
// - shutdown bit clear forces pwm outputs off immediately, adc trigger not gated
// - shutdown bit set restores modulator at reload
// - override select gates outputs per override bit
// - alignment bit: 0 edge, 1 center aligned
// - adc trigger pulses only while enable bit set
// - ready at reload copies holding into working
// - not ready at reload keeps working values
// - new duty takes effect only at reload
// - reload every 1,2,4,8 periods per field
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

`define PMC_ADDR_W        24
`define PMC_OFS_CTL       24'hffe380
`define PMC_OFS_OVR       24'hffe384
`define PMC_OFS_CFG       24'hffe388
`define PMC_OFS_PERIOD    24'hffe38c
`define PMC_OFS_DUTY0     24'hffe390
`define PMC_OFS_DUTY1     24'hffe394
`define PMC_OFS_DUTY2     24'hffe398
`define PMC_OFS_STATUS    24'hffe39c

`define PMC_CTL_SHUTDOWN  7
`define PMC_CTL_OVR_SEL   6
`define PMC_CTL_ALIGN     5
`define PMC_CTL_ADC_EN    3
`define PMC_CTL_READY     1
`define PMC_CTL_ENABLE    0
`define PMC_CTL_RESET     8'h00

`define PMC_CFG_PRES_LSB  0
`define PMC_CFG_RLF_LSB   6
`define PMC_CFG_RESET     8'h00
`define PMC_OVR_RESET     6'h00
`define PMC_PERIOD_RESET  12'hfff
`define PMC_DUTY_RESET    14'h0000
`define PMC_DUTY_SIGN     13
`define PMC_MIN_PERIOD    12'h001
`define PMC_OFF_LEVEL     6'h00

`define PMC_STAT_MOD_LSB  16
`define PMC_STAT_RUN_LSB  17

`define PMC_RESP_OKAY     2'h0
`define PMC_RESP_SLVERR   2'h2

`endif

// ===== design/pmc_pkg.sv
// types shared by the pwm master control modules
package pmc_pkg;

    typedef logic [11:0] pmc_cnt_t;
    typedef logic [13:0] pmc_duty_t;

    typedef enum logic {
        PMC_EDGE   = 1'b0,
        PMC_CENTER = 1'b1
    } pmc_align_e;

    typedef struct packed {
        pmc_align_e  align;
        pmc_cnt_t    period;
        logic [1:0]  prescale;
        logic [1:0]  reload_frequency_sel;
    } pmc_tb_cfg_s;

    typedef struct packed {
        pmc_cnt_t    count;
        logic        period_end;
        logic        reload;
    } pmc_tb_evt_s;

    typedef struct packed {
        logic [23:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [23:0] araddr;
        logic        arvalid;
        logic        rready;
    } pmc_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } pmc_axi_rsp_s;

    // divide-by-2^code expressed as a terminal count
    function automatic logic [2:0] pmc_mask(input logic [1:0] code);
        unique case (code)
            2'h0:    pmc_mask = 3'h0;
            2'h1:    pmc_mask = 3'h1;
            2'h2:    pmc_mask = 3'h3;
            2'h3:    pmc_mask = 3'h7;
        endcase
    endfunction

    function automatic logic [31:0] pmc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
        pmc_merge = old_v;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
                pmc_merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
    endfunction

endpackage

// ===== design/pmc_timebase.sv
// master pwm counter with prescaler, alignment and reload event divider
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"

module pmc_timebase
    import pmc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        enable,
    input  wire pmc_tb_cfg_s cfg,
    output var  pmc_tb_evt_s evt
);

    typedef struct packed {
        logic [2:0] pre;
        pmc_cnt_t   cnt;
        logic       down;
        logic [2:0] per;
        logic [1:0] rlf;
        logic       pend;
        logic       reload;
    } pmc_tb_st_s;

    pmc_tb_st_s q;
    pmc_tb_st_s d;
    pmc_cnt_t   pmax;

    always_comb
    begin
        d        = q;
        d.pend   = 1'b0;
        d.reload = 1'b0;
        // a zero period would never wrap; run it as the shortest period
        pmax = (cfg.period == '0) ? `PMC_MIN_PERIOD : cfg.period;
        if (!enable)
        begin
            d     = '0;
            d.rlf = cfg.reload_frequency_sel;
        end
        else if (q.pre != pmc_mask(cfg.prescale))
            d.pre = q.pre + 3'h1;
        else
        begin
            d.pre = '0;
            if (cfg.align == PMC_EDGE)
            begin
                d.down = 1'b0;
                if (q.cnt >= pmax - 12'h1)
                begin
                    d.cnt  = '0;
                    d.pend = 1'b1;
                end
                else
                    d.cnt = q.cnt + 12'h1;
            end
            else if (!q.down)
            begin
                if (q.cnt >= pmax)
                begin
                    d.down = 1'b1;
                    d.cnt  = q.cnt - 12'h1;
                end
                else
                    d.cnt = q.cnt + 12'h1;
            end
            else if (q.cnt <= 12'h1)
            begin
                d.cnt  = '0;
                d.down = 1'b0;
                d.pend = 1'b1;
            end
            else
                d.cnt = q.cnt - 12'h1;

            // frequency field only changes at a period boundary, or every clock while disabled
            if (d.pend)
            begin
                d.rlf = cfg.reload_frequency_sel;
                if (q.per == pmc_mask(q.rlf))
                begin
                    d.per    = '0;
                    d.reload = 1'b1;
                end
                else
                    d.per = q.per + 3'h1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= '0;
        else
            q <= d;
    end

    assign evt = '{count: q.cnt, period_end: q.pend, reload: q.reload};

endmodule
`default_nettype wire

// ===== verification/pmc_drive_model.sv
// stand-in for gate drivers and adc: counts high cycles inside a window
`timescale 1ns/1ps
`default_nettype none
module pmc_drive_model
(
    input  wire logic            aclk,
    input  wire logic            win,
    input  wire logic [6:0]      pins,
    output var  logic [6:0][7:0] hi_cnt
);
    logic win_q;

    // pins[6] is the adc trigger, the rest are the six gate inputs
    always_ff @(posedge aclk)
    begin
        win_q <= win;
        for (int i = 0; i < 7; i++)
        begin
            if (win)
                hi_cnt[i] <= (win_q ? hi_cnt[i] : 8'h00) + 8'(pins[i]);
        end
    end
endmodule
`default_nettype wire

// ===== verification/pmc_top_props.sv
// concurrent checks on the ports of the pwm master control top
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"
module pmc_top_props
    import pmc_pkg::*;
(
    input wire logic         aclk,
    input wire logic         aresetn,
    input wire pmc_axi_req_s axi_req,
    input wire pmc_axi_rsp_s axi_rsp,
    input wire logic [5:0]   pwm_out,
    input wire logic         adc_trigger
);
    // shadow of the control word; histories span the write-to-pin lag
    logic [7:0] sh_q;
    logic [4:0] sd_q, en_q, ad_q;
    logic       bad_q;
    wire logic  aw_go = axi_req.awvalid && axi_rsp.awready;
    wire logic  w_go = axi_req.wvalid && axi_rsp.wready;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sh_q <= 8'h00;
            sd_q <= 5'h00;
            en_q <= 5'h00;
            ad_q <= 5'h00;
            bad_q <= 1'b0;
        end
        else
        begin
            if (aw_go && w_go && axi_req.awaddr == `PMC_OFS_CTL)
                sh_q <= axi_req.wdata[7:0];
            if (aw_go)
                bad_q <= axi_req.awaddr < `PMC_OFS_CTL
                    || axi_req.awaddr > `PMC_OFS_STATUS + 24'h3;
            sd_q <= {sd_q[3:0], sh_q[`PMC_CTL_SHUTDOWN]};
            en_q <= {en_q[3:0], sh_q[`PMC_CTL_ENABLE]};
            ad_q <= {ad_q[3:0], sh_q[`PMC_CTL_ADC_EN]};
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_wr_answer: assert property (aw_go && w_go |=> !axi_rsp.bvalid
        ##1 axi_rsp.bvalid) else $error("write answer mistimed");
    a_rd_answer: assert property (axi_req.arvalid && axi_rsp.arready
        |=> axi_rsp.rvalid) else $error("read answer mistimed");
    a_b_holds: assert property (axi_rsp.bvalid && !axi_req.bready
        |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
        else $error("write answer dropped");
    a_r_holds: assert property (axi_rsp.rvalid && !axi_req.rready
        |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read answer dropped");
    a_aw_refused: assert property (axi_rsp.bvalid |-> !axi_rsp.awready)
        else $error("address taken during answer");
    a_resp_code: assert property (axi_rsp.bvalid |-> axi_rsp.bresp ==
        (bad_q ? `PMC_RESP_SLVERR : `PMC_RESP_OKAY))
        else $error("write response code wrong");
    a_rst_quiet: assert property (
        $rose(aresetn) |-> pwm_out == `PMC_OFF_LEVEL && !adc_trigger)
        else $error("outputs active after reset");
    a_shut_off: assert property (
        !(|sd_q) |-> pwm_out == `PMC_OFF_LEVEL)
        else $error("pins driven while shut down");
    a_dis_off: assert property (
        !(|en_q) |-> pwm_out == `PMC_OFF_LEVEL && !adc_trigger)
        else $error("activity while disabled");
    a_adc_quiet: assert property (!(|ad_q) |-> !adc_trigger)
        else $error("adc trigger while disabled");

    c_adc: cover property (adc_trigger);
    c_slverr: cover property (axi_rsp.bvalid && bad_q);
    c_pwm: cover property ($rose(pwm_out[0]));
endmodule
`default_nettype wire

// ===== verification/pmc_top_tb.sv
// testbench of the pwm master control: bus tasks, one task per scenario
`timescale 1ns/1ps
`default_nettype none
`include "pmc_map.svh"
module pmc_top_tb
    import pmc_pkg::*;
;
    logic            aclk;
    logic            aresetn;
    pmc_axi_req_s    req;
    pmc_axi_rsp_s    rsp;
    logic [5:0]      pwm;
    logic            adc;
    logic            win;
    logic [6:0][7:0] hi_cnt;
    logic [31:0]     d;
    int              error_cnt = 0;
    int              samples_checked = 0;
    int              cyc = 0;

    pmc_top DUT (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
        .axi_rsp(rsp), .pwm_out(pwm), .adc_trigger(adc));
    pmc_drive_model u_stage (.aclk(aclk), .win(win), .pins({adc, pwm}),
        .hi_cnt(hi_cnt));

    task automatic chk(input string n, input logic [31:0] e, s);
        samples_checked++;
        if (s !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [23:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        req.awaddr <= a;
        req.wdata <= v;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        while (!(ad && wd))
        begin
            @(posedge aclk);
            if (rsp.awready)
                req.awvalid <= 1'b0;
            if (rsp.wready)
                req.wvalid <= 1'b0;
            ad |= rsp.awready;
            wd |= rsp.wready;
        end
        // bready comes late so the answer is seen waiting
        repeat (2) @(posedge aclk);
        req.bready <= 1'b1;
        do
            @(posedge aclk);
        while (!rsp.bvalid);
        chk("write response", er, rsp.bresp);
        req.bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [23:0] a, input logic [1:0] er);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do
            @(posedge aclk);
        while (!rsp.arready);
        req.arvalid <= 1'b0;
        @(posedge aclk);
        req.rready <= 1'b1;
        do
            @(posedge aclk);
        while (!rsp.rvalid);
        d = rsp.rdata;
        chk("read response", er, rsp.rresp);
        req.rready <= 1'b0;
        @(posedge aclk);
    endtask

    task poll;
        do
            rd(`PMC_OFS_CTL, 2'h0);
        while (d[`PMC_CTL_READY]);
    endtask

    task meas(input int n);
        win <= 1'b1;
        repeat (n) @(posedge aclk);
        win <= 1'b0;
        @(posedge aclk);
    endtask

    task chk_hi(input int n, input logic [47:0] e);
        meas(n);
        for (int i = 0; i < 6; i++)
            chk("pwm high count", e[i*8 +: 8], hi_cnt[i]);
    endtask

    task t_start;
        rd(`PMC_OFS_CTL, 2'h0);
        chk("control reset", 32'h0, d);
        rd(24'hffe3a0, 2'h2);
        chk("unmapped read", 32'h0, d);
        wr(24'hffe3a0, 32'h5a, 2'h2);
        wr(`PMC_OFS_PERIOD, 32'h8, 2'h0);
        wr(`PMC_OFS_DUTY0, 32'h4, 2'h0);
        wr(`PMC_OFS_DUTY1, 32'h2004, 2'h0);
        wr(`PMC_OFS_DUTY2, 32'h100, 2'h0);
        wr(`PMC_OFS_CTL, 32'h83, 2'h0);
        chk_hi(16, 48'h0);
        poll;
        repeat (8) @(posedge aclk);
        chk_hi(16, 48'h00_10_10_00_08_08);
    endtask

    task t_modes;
        wr(`PMC_OFS_DUTY0, 32'h2, 2'h0);
        repeat (24) @(posedge aclk);
        chk_hi(16, 48'h00_10_10_00_08_08);
        wr(`PMC_OFS_CTL, 32'h83, 2'h0);
        poll;
        repeat (8) @(posedge aclk);
        chk_hi(16, 48'h00_10_10_00_0c_04);
        wr(`PMC_OFS_OVR, 32'h11, 2'h0);
        wr(`PMC_OFS_CTL, 32'hc1, 2'h0);
        chk_hi(16, 48'h00_00_10_00_0c_00);
        wr(`PMC_OFS_CTL, 32'ha1, 2'h0);
        repeat (24) @(posedge aclk);
        chk_hi(16, 48'h00_10_10_00_0d_03);
        wr(`PMC_OFS_CTL, 32'h89, 2'h0);
        meas(32);
        chk("adc pulses", 32'h4, hi_cnt[6]);
        wr(`PMC_OFS_CTL, 32'h81, 2'h0);
        meas(32);
        chk("adc pulses", 32'h0, hi_cnt[6]);
    endtask

    task t_reload;
        int t;
        wr(`PMC_OFS_PERIOD, 32'h20, 2'h0);
        for (int c = 0; c < 4; c++)
        begin
            wr(`PMC_OFS_CFG, 32'(c << 6), 2'h0);
            wr(`PMC_OFS_CTL, 32'h83, 2'h0);
            poll;
            t = cyc;
            wr(`PMC_OFS_CTL, 32'h83, 2'h0);
            poll;
            t = cyc - t - (32 << c);
            chk("reload spacing", 32'h1, 32'(t > -7 && t < 7));
        end
        // prescale is buffered too: a tick every second clock, 64-cycle period
        wr(`PMC_OFS_CFG, 32'h1, 2'h0);
        wr(`PMC_OFS_CTL, 32'h83, 2'h0);
        poll;
        chk_hi(64, 48'h00_40_40_00_3c_04);
    endtask

    task t_off;
        wr(`PMC_OFS_CTL, 32'h80, 2'h0);
        chk_hi(16, 48'h0);
        rd(`PMC_OFS_STATUS, 2'h0);
        chk("stopped count", 32'h0, d & 32'h2_0fff);
        wr(`PMC_OFS_CTL, 32'h01, 2'h0);
        chk_hi(16, 48'h0);
    endtask

    task final_report;
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ceiling: the first reload waits out the 4095-count reset period
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            error_cnt++;
            final_report();
        end
    end

    initial
    begin
        req = '0;
        req.wstrb = 4'hf;
        aresetn = 1'b0;
        win = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_start();
        t_modes();
        t_reload();
        t_off();
        final_report();
    end
endmodule

bind pmc_top pmc_top_props u_props (.aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .pwm_out(pwm_out),
    .adc_trigger(adc_trigger));
`default_nettype wire
